// ### hw/sps_defines.svh
// sps_defines.svh: offsets, field positions, reset values and timing counts of the synthesizer core
// assumes a 4 MHz crystal square wave and the 25 MHz system clock
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// crystal and derived frequencies
`define SPS_XTAL_HZ 64'd4000000
`define SPS_CLK_OUT_HZ 64'd500000
`define SPS_REF_MILLIHZ 64'd3906250
`define SPS_CLK_OUT_DIV (`SPS_XTAL_HZ / `SPS_CLK_OUT_HZ)
`define SPS_REF_DIV ((`SPS_XTAL_HZ * 64'd1000) / `SPS_REF_MILLIHZ)

// control word layout, first bit shifted in lands at the top
`define SPS_WORD_W 19
`define SPS_MAIN_W 10
`define SPS_SWAL_W 5
`define SPS_BAND_W 4
`define SPS_MAIN_LSB 9
`define SPS_SWAL_LSB 4
`define SPS_BAND_LSB 0

// divider figures
`define SPS_MOD_LOW 6'h20
`define SPS_MAIN_MIN 10'h020

// reset values of the holding latch
`define SPS_MAIN_RST 10'h020
`define SPS_SWAL_RST 5'h00
`define SPS_BAND_RST 4'h0

`endif

// ### hw/sps_pkg.sv
// sps_pkg: types shared by the synthesizer core files
// assumes sps_defines.svh sits on the include path
`include "sps_defines.svh"

package sps_pkg;

  typedef struct packed {
    logic [`SPS_MAIN_W-1:0] main_count;
    logic [`SPS_SWAL_W-1:0] swallow_count;
    logic [`SPS_BAND_W-1:0] band;
  } sps_word_t;

  typedef enum logic [1:0] {
    SPS_IN_PHASE = 2'b00,
    SPS_DIV_LEAD = 2'b01,
    SPS_REF_LEAD = 2'b10
  } sps_phase_t;

endpackage

// ### hw/sps_shift_in.sv
// sps_shift_in: serial shift register on the host's serial clock
// assumes the host keeps the serial clock still while enable is low
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_shift_in #(
  parameter int WORD_W = `SPS_WORD_W
) (
  // link side
  input wire logic serial_clk,
  input wire logic arst_n,
  input wire logic serial_data,
  input wire logic serial_enable,
  // word out, quasi-static once enable falls
  output logic [WORD_W-1:0] shift_word
);

  logic [WORD_W-1:0] shift_r;

  // a shift needs at least two stages
  generate
    if (WORD_W < 2) begin : g_bad_width
      $error("shift word too narrow");
    end
  endgenerate

  // bits only move while enable is high, on the falling serial clock edge
  always_ff @(negedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
    end else if (serial_enable) begin
      shift_r <= {shift_r[WORD_W-2:0], serial_data};
    end
  end

  assign shift_word = shift_r;

endmodule

// ### hw/sps_prog_div.sv
// sps_prog_div: 32/33 dual-modulus stage with main and swallow counters
// assumes a one-cycle pulse per rising edge of the external divide-by-8 prescaler
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_prog_div #(
  parameter int MAIN_W = `SPS_MAIN_W,
  parameter int SWAL_W = `SPS_SWAL_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // prescaler edges and loaded counts
  input wire logic pre_pulse,
  input wire logic [MAIN_W-1:0] main_count,
  input wire logic [SWAL_W-1:0] swallow_count,
  // one pulse per divider cycle
  output logic div_tick
);

  logic [5:0] mod_cnt_r;
  logic [MAIN_W-1:0] main_left_r;
  logic [SWAL_W-1:0] swal_left_r;
  logic div_tick_r;
  logic [5:0] mod_top;

  // the 32/33 stage and its six-bit counter only serve a five-bit swallow count
  generate
    if (SWAL_W != 5 || MAIN_W < 6) begin : g_bad_width
      $error("divider counter widths not supported");
    end
  endgenerate

  // 33 while swallowing, 32 afterwards
  assign mod_top = (swal_left_r != '0) ? `SPS_MOD_LOW : `SPS_MOD_LOW - 6'h01;

  // modulus counter counts up; main and swallow are plain binary down counters, reloaded from the latch each divider cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mod_cnt_r <= 6'h00;
      main_left_r <= `SPS_MAIN_RST;
      swal_left_r <= `SPS_SWAL_RST;
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= 1'b0;
      if (pre_pulse) begin
        if (mod_cnt_r == mod_top) begin
          mod_cnt_r <= 6'h00;
          if (main_left_r <= {{(MAIN_W-1){1'b0}}, 1'b1}) begin
            main_left_r <= main_count;
            swal_left_r <= swallow_count;
            div_tick_r <= 1'b1;
          end else begin
            main_left_r <= main_left_r - 1'b1;
            if (swal_left_r != '0) begin
              swal_left_r <= swal_left_r - 1'b1;
            end
          end
        end else begin
          mod_cnt_r <= mod_cnt_r + 6'h01;
        end
      end
    end
  end

  assign div_tick = div_tick_r;

endmodule

// ### hw/sps_synth_core.sv
// sps_synth_core: digital core of the serially programmed tuner synthesizer
// assumes crystal square wave and prescaler output arrive as pins, sampled on clock
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_synth_core
  import sps_pkg::*;
#(
  parameter int WORD_W = `SPS_WORD_W,
  parameter int MAIN_W = `SPS_MAIN_W,
  parameter int SWAL_W = `SPS_SWAL_W,
  parameter int BAND_W = `SPS_BAND_W,
  parameter int CLK_OUT_DIV = int'(`SPS_CLK_OUT_DIV),
  parameter int REF_DIV = int'(`SPS_REF_DIV)
) (
  // system clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // host serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_enable,
  // pins from the analog side and test
  input wire logic xtal_in,
  input wire logic prescaler_in,
  input wire logic test_select,
  // shared outputs, level low means the open collector sinks
  output logic clk_or_ref_out,
  output logic lock_or_divider_out,
  // phase comparator three-state pins
  output logic phase_error_out_a,
  output logic phase_error_out_a_oe,
  output logic phase_error_out_b,
  output logic phase_error_out_b_oe,
  // band switching, high means sinking
  output logic band_switch_out_a,
  output logic band_switch_out_b,
  output logic band_switch_out_c,
  output logic band_switch_out_d
);

  import sps_pkg::*;

  localparam int REF_W = $clog2(REF_DIV);
  localparam int CLK_BIT = $clog2(CLK_OUT_DIV) - 1;

  generate
    if (WORD_W != MAIN_W + SWAL_W + BAND_W || BAND_W != 4) begin : g_bad_word
      $error("control word width does not match its fields");
    end
    if (REF_DIV != (1 << REF_W) || CLK_OUT_DIV != (1 << (CLK_BIT + 1)) || CLK_OUT_DIV > REF_DIV) begin : g_bad_div
      $error("crystal dividers must be powers of two");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // serial link domain

  logic [WORD_W-1:0] shift_word;

  sps_shift_in #(
    .WORD_W(WORD_W)
  ) u_shift (
    .serial_clk(serial_clk),
    .arst_n(arst_n),
    .serial_data(serial_data),
    .serial_enable(serial_enable),
    .shift_word(shift_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] en_sync_r;
  logic en_old_r;
  logic [1:0] xtal_sync_r;
  logic xtal_old_r;
  logic [1:0] pre_sync_r;
  logic pre_old_r;
  logic [1:0] test_sync_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_sync_r <= 2'h0;
      en_old_r <= 1'b0;
      xtal_sync_r <= 2'h0;
      xtal_old_r <= 1'b0;
      pre_sync_r <= 2'h0;
      pre_old_r <= 1'b0;
      test_sync_r <= 2'h0;
    end else begin
      en_sync_r <= {en_sync_r[0], serial_enable};
      en_old_r <= en_sync_r[1];
      xtal_sync_r <= {xtal_sync_r[0], xtal_in};
      xtal_old_r <= xtal_sync_r[1];
      pre_sync_r <= {pre_sync_r[0], prescaler_in};
      pre_old_r <= pre_sync_r[1];
      test_sync_r <= {test_sync_r[0], test_select};
    end
  end

  logic en_fall;
  logic xtal_rise;
  logic pre_rise;
  logic test_on;

  assign en_fall = en_old_r & ~en_sync_r[1];
  assign xtal_rise = xtal_sync_r[1] & ~xtal_old_r;
  assign pre_rise = pre_sync_r[1] & ~pre_old_r;
  assign test_on = test_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // holding latch

  // word is quasi-static here: the serial clock rests while enable is low
  sps_word_t latch_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= '{main_count: `SPS_MAIN_RST, swallow_count: `SPS_SWAL_RST, band: `SPS_BAND_RST};
    end else if (en_fall) begin
      latch_r.main_count <= shift_word[`SPS_MAIN_LSB +: MAIN_W];
      latch_r.swallow_count <= shift_word[`SPS_SWAL_LSB +: SWAL_W];
      latch_r.band <= shift_word[`SPS_BAND_LSB +: BAND_W];
    end
  end

  // out-of-range main counts are host errors; the floor keeps the swallow scheme valid
  logic [MAIN_W-1:0] main_used;

  assign main_used = (latch_r.main_count < `SPS_MAIN_MIN) ? `SPS_MAIN_MIN : latch_r.main_count;

  ////////////////////////////////////////////////////////////////////////////
  // reference divider from the crystal

  logic [REF_W-1:0] ref_cnt_r;
  logic ref_tick_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_r <= '0;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (xtal_rise) begin
        ref_cnt_r <= ref_cnt_r + 1'b1;
        ref_tick_r <= (ref_cnt_r == {REF_W{1'b1}});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programmable divider

  logic div_tick;
  logic div_sq_r;

  sps_prog_div #(
    .MAIN_W(MAIN_W),
    .SWAL_W(SWAL_W)
  ) u_div (
    .clock(clock),
    .arst_n(arst_n),
    .pre_pulse(pre_rise),
    .main_count(main_used),
    .swallow_count(latch_r.swallow_count),
    .div_tick(div_tick)
  );

  // square wave at half the divider rate for the test pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_sq_r <= 1'b0;
    end else if (div_tick) begin
      div_sq_r <= ~div_sq_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase comparator

  // locked loop then tunes to ref times 8(32M+S), a 31.25 kHz step
  sps_phase_t phase_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= SPS_IN_PHASE;
    end else begin
      case (phase_r)
        SPS_IN_PHASE: begin
          if (div_tick && !ref_tick_r) begin
            phase_r <= SPS_DIV_LEAD;
          end else if (ref_tick_r && !div_tick) begin
            phase_r <= SPS_REF_LEAD;
          end
        end
        SPS_DIV_LEAD: begin
          if (ref_tick_r) begin
            phase_r <= SPS_IN_PHASE;
          end
        end
        SPS_REF_LEAD: begin
          if (div_tick) begin
            phase_r <= SPS_IN_PHASE;
          end
        end
        default: begin
          phase_r <= SPS_IN_PHASE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  logic lock_indicator;

  assign lock_indicator = (phase_r == SPS_IN_PHASE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clk_or_ref_out <= 1'b0;
      lock_or_divider_out <= 1'b1;
    end else begin
      clk_or_ref_out <= test_on ? ref_cnt_r[REF_W-1] : ref_cnt_r[CLK_BIT];
      lock_or_divider_out <= test_on ? div_sq_r : lock_indicator;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_error_out_a <= 1'b0;
      phase_error_out_a_oe <= 1'b0;
      phase_error_out_b <= 1'b0;
      phase_error_out_b_oe <= 1'b0;
    end else begin
      phase_error_out_a <= (phase_r == SPS_DIV_LEAD);
      phase_error_out_b <= (phase_r == SPS_DIV_LEAD);
      phase_error_out_a_oe <= !test_on && !lock_indicator;
      phase_error_out_b_oe <= !test_on && !lock_indicator;
    end
  end

  // band a is the first band bit shifted in
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      band_switch_out_a <= 1'b0;
      band_switch_out_b <= 1'b0;
      band_switch_out_c <= 1'b0;
      band_switch_out_d <= 1'b0;
    end else begin
      band_switch_out_a <= latch_r.band[3];
      band_switch_out_b <= latch_r.band[2];
      band_switch_out_c <= latch_r.band[1];
      band_switch_out_d <= latch_r.band[0];
    end
  end

endmodule

// ### testbench/sps_synth_core_sva.sv
// sps_synth_core_sva: port-level checks of the synthesizer core
// assumes the crystal pin toggles well below the system clock rate
`timescale 1ns/1ps

module sps_synth_core_sva (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // inputs watched
  input wire logic serial_enable,
  input wire logic xtal_in,
  input wire logic test_select,
  // outputs watched
  input wire logic clk_or_ref_out,
  input wire logic lock_or_divider_out,
  input wire logic phase_error_out_a,
  input wire logic phase_error_out_a_oe,
  input wire logic phase_error_out_b,
  input wire logic phase_error_out_b_oe,
  input wire logic band_switch_out_a,
  input wire logic band_switch_out_b,
  input wire logic band_switch_out_c,
  input wire logic band_switch_out_d
);
  logic xq_r, oq_r, tq_r, seen_r;
  logic [9:0] xc_r;
  logic [3:0] tc_r;
  wire chg = clk_or_ref_out != oq_r;
  wire calm = tc_r == 4'hf && test_select == tq_r;
  wire [3:0] bands = {band_switch_out_a, band_switch_out_b, band_switch_out_c, band_switch_out_d};
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
////////////////////
  // crystal rises between output edges; only judged once test has been quiet
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      xq_r <= 1'b0;
      oq_r <= 1'b0;
      tq_r <= 1'b0;
      seen_r <= 1'b0;
      xc_r <= 10'h0;
      tc_r <= 4'h0;
    end else begin
      xq_r <= xtal_in;
      oq_r <= clk_or_ref_out;
      tq_r <= test_select;
      seen_r <= calm && (chg || seen_r);
      xc_r <= (chg ? 10'h0 : xc_r) + {9'h0, xtal_in && !xq_r};
      tc_r <= (test_select != tq_r) ? 4'h0 : tc_r + {3'h0, tc_r != 4'hf};
    end
  end
////////////////////
  sequence s_floated;
    !phase_error_out_a_oe && !phase_error_out_b_oe;
  endsequence
  a_clk_half_period: assert property (chg && seen_r && calm && !test_select |-> xc_r == 10'h4)
    else $error("clock output half period wrong");
  a_ref_half_period: assert property (chg && seen_r && calm && test_select |-> xc_r == 10'h200)
    else $error("reference output half period wrong");
  a_float_in_test: assert property (calm && test_select |-> s_floated)
    else $error("phase outputs driven in test mode");
  a_float_on_switch: assert property ($rose(test_select) |-> ##[1:6] s_floated [*2])
    else $error("phase outputs not floated after test entry");
  a_lock_mirrors_oe: assert property (calm && !test_select |-> lock_or_divider_out == !phase_error_out_a_oe)
    else $error("lock output disagrees with phase outputs");
  a_outputs_paired: assert property (phase_error_out_a_oe |->
    phase_error_out_b_oe && phase_error_out_a == phase_error_out_b)
    else $error("phase outputs differ");
  a_level_held: assert property (phase_error_out_a_oe && $past(phase_error_out_a_oe) |-> $stable(phase_error_out_a))
    else $error("phase level flipped while driven");
  a_bands_quiet_frame: assert property (serial_enable && $past(serial_enable, 8) |-> $stable(bands))
    else $error("band outputs moved during a frame");
endmodule

// ### testbench/sps_host_model.sv
// sps_host_model: tuner host controller on the serial link
// assumes the core shifts on the falling serial clock
`timescale 1ns/1ps

module sps_host_model (
  // serial link
  output logic serial_clk,
  output logic serial_data,
  output logic serial_enable
);
  import sps_pkg::*;
  initial begin
    serial_clk = 1'b1;
    serial_data = 1'b0;
    serial_enable = 1'b0;
  end
////////////////////
  // one frame, a bit every 160 ns; clock stands still outside it
  task automatic send(input sps_word_t w);
    logic [18:0] v;
    v = w;
    #37 serial_enable = 1'b1;
    for (int i = 18; i >= 0; i--) begin
      serial_data = v[i];
      #80 serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
    end
    #80 serial_enable = 1'b0;
    // released line shows the inverse, so a stale bit cannot pass
    serial_data = ~v[0];
    #400;
  endtask
endmodule

// ### testbench/tb_top.sv
// tb_top: self-checking bench for the synthesizer core
// assumes the host model drives the link and the checker is bound below
`timescale 1ns/1ps

module tb_top;
  import sps_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic xtal_in = 1'b0;
  logic prescaler_in = 1'b0;
  logic test_select = 1'b0;
  logic serial_clk, serial_data, serial_enable, clk_or_ref_out, lock_or_divider_out;
  logic phase_error_out_a, phase_error_out_a_oe, phase_error_out_b, phase_error_out_b_oe;
  logic band_switch_out_a, band_switch_out_b, band_switch_out_c, band_switch_out_d;
  logic [31:0] lfsr_r = 32'h3aba;
  int err_total = 0;
  int cmp_count = 0;
  int ph = 0;
  int xt_rise = 0;
  int ps_rise = 0;
  int exp_q[$];
  int n;
  sps_word_t w;
  wire [3:0] bands = {band_switch_out_a, band_switch_out_b, band_switch_out_c, band_switch_out_d};

  always #20 clock = ~clock;
  sps_host_model host (.serial_clk, .serial_data, .serial_enable);
  sps_synth_core DUT (.clock, .arst_n, .serial_clk, .serial_data, .serial_enable, .xtal_in,
    .prescaler_in, .test_select, .clk_or_ref_out, .lock_or_divider_out, .phase_error_out_a,
    .phase_error_out_a_oe, .phase_error_out_b, .phase_error_out_b_oe, .band_switch_out_a,
    .band_switch_out_b, .band_switch_out_c, .band_switch_out_d);
////////////////////
  // crystal and prescaler near 4.17 MHz, a third of a period apart
  always @(posedge clock) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2) xtal_in <= ~xtal_in;
    if (ph == 2 && !xtal_in) xt_rise <= xt_rise + 1;
    if (ph == 0) prescaler_in <= ~prescaler_in;
    if (ph == 0 && !prescaler_in) ps_rise <= ps_rise + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // input rises between two changes of an output
  task automatic meas(input bit sel, output int cnt);
    logic v0;
    int a;
    v0 = sel ? lock_or_divider_out : clk_or_ref_out;
    for (int i = 0; i < 40000 && (sel ? lock_or_divider_out : clk_or_ref_out) === v0; i++) @(posedge clock);
    a = sel ? ps_rise : xt_rise;
    v0 = ~v0;
    for (int i = 0; i < 40000 && (sel ? lock_or_divider_out : clk_or_ref_out) === v0; i++) @(posedge clock);
    cnt = (sel ? ps_rise : xt_rise) - a;
  endtask

  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
////////////////////
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'({bands, phase_error_out_a_oe, phase_error_out_b_oe, lock_or_divider_out}), 32'h1);
    for (int k = 0; k < 4; k++) begin
      repeat (8) lfsr_r = lfsr_next(lfsr_r);
      // main kept low so a divider cycle fits the run
      w.main_count = {5'h01, lfsr_r[4:0]};
      w.swallow_count = lfsr_r[9:5];
      w.band = lfsr_r[13:10];
      exp_q.push_back(32 * int'(w.main_count) + int'(w.swallow_count));
      host.send(w);
      repeat (8) @(posedge clock);
      chk(32'(bands), 32'(w.band));
    end
    meas(1'b0, n);
    meas(1'b0, n);
    chk(32'(n), 32'h4);
    meas(1'b1, n);
    chk(32'({lock_or_divider_out, phase_error_out_a_oe}), 32'h2);
    test_select <= 1'b1;
    repeat (10) @(posedge clock);
    chk(32'({phase_error_out_a_oe, phase_error_out_b_oe}), 32'h0);
    meas(1'b0, n);
    meas(1'b0, n);
    chk(32'(n), 32'h200);
    meas(1'b1, n);
    meas(1'b1, n);
    chk(32'(n), 32'(exp_q[$]));
    give_verdict();
  end

  initial begin
    repeat (99000) @(posedge clock);
    err_total++;
    give_verdict();
  end
endmodule

bind sps_synth_core sps_synth_core_sva u_sva (
  .clock, .arst_n, .serial_enable, .xtal_in, .test_select, .clk_or_ref_out, .lock_or_divider_out,
  .phase_error_out_a, .phase_error_out_a_oe, .phase_error_out_b, .phase_error_out_b_oe,
  .band_switch_out_a, .band_switch_out_b, .band_switch_out_c, .band_switch_out_d
);
